// ===== gvp_pkg.sv
// Shared constants, types and register map of the gas valve proving sequencer
package gvp_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_EVAC = 8'h08;
  localparam logic [7:0] REG_ATM = 8'h0c;
  localparam logic [7:0] REG_FILL = 8'h10;
  localparam logic [7:0] REG_GASP = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_IRQ = 8'h1c;
  localparam logic [7:0] REG_MASK = 8'h20;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_GAS_BIT = 2;
  // Command register fields (write-one pulses)
  localparam int CMD_MRST_BIT = 0;

  // Status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_MODE_LSB = 3;
  localparam int STAT_LOCK_BIT = 5;
  localparam int STAT_FORCE_BIT = 6;
  localparam int STAT_PASS_BIT = 7;
  localparam int STAT_ERR_LSB = 16;

  // Interrupt status and mask bits
  localparam int IRQ_W = 6;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_LEAKG = 1;
  localparam int IRQ_LEAKB = 2;
  localparam int IRQ_INVAL = 3;
  localparam int IRQ_SUPPLY = 4;
  localparam int IRQ_ABORT = 5;

  // Error codes reported in the status register
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_SUPPLY = 16'h03fc;
  localparam logic [15:0] ERR_LEAK_GAS = 16'h03fe;
  localparam logic [15:0] ERR_LEAK_BURNER = 16'h03ff;
  localparam logic [15:0] ERR_INVALID = 16'h0400;

  // Startup sequence phase that hosts the startup test
  localparam logic [7:0] PHASE_PROVING = 8'h1e;

  // Step time base
  localparam int TIME_W = 16;
  localparam int CLK_PERIOD_NS = 50;
  localparam int STEP_UNIT_NS = 1000000;
  localparam int CYC_PER_MS = STEP_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [TIME_W-1:0] STEP_TIME_RST = 16'h03e8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Test mode encoding
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_STARTUP = 2'h1,
    MODE_SHUTDOWN = 2'h2,
    MODE_BOTH = 2'h3
  } gvp_mode_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EVAC,
    ST_ATM,
    ST_FILL,
    ST_GASP,
    ST_LOCK
  } gvp_state_t;

  // Contact inputs, 1 = contact closed
  typedef struct packed {
    logic provingClosed;
    logic safetyClosed;
    logic gasStartClosed;
  } gvp_pins_t;

  localparam gvp_pins_t PINS_RST = 3'h0;

endpackage

// ===== gvp_sequencer.sv
// Gas valve proving sequencer with AXI4-Lite registers and interrupt
`timescale 1ns/1ps
module gvp_sequencer
  import gvp_pkg::*;
#(
  parameter int CYC_PER_STEP_MS = CYC_PER_MS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire gvp_pins_t pinsIn,
  input wire logic [7:0] seqPhase,
  input wire logic shutdownReq,
  input wire logic nvLockoutIn,
  output logic burnerValve,
  output logic mainsValve,
  output logic ignitionBlock,
  output logic testBusy,
  output logic testPassed,
  output logic lockout,
  output logic irq
);

  localparam int PRE_W = $clog2(CYC_PER_STEP_MS + 1);

  // Expand byte strobes to a bit mask
  function automatic logic [31:0] strbMask(input logic [3:0] s);
    strbMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // Merge new write data into an old word under byte strobes
  function automatic logic [31:0] mergeWord(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] s);
    mergeWord = (nw & strbMask(s)) | (old & ~strbMask(s));
  endfunction

  // Synchronised contact inputs
  gvp_pins_t pins;
  gvp_sync #(.WIDTH(3), .RST_VAL(PINS_RST)) uSync (
    .clk(clk),
    .nrst(nrst),
    .din(pinsIn),
    .dout(pins)
  );

  // Software visible state
  gvp_mode_t pendingMode; // Mode as last written
  gvp_mode_t activeMode; // Mode in force
  logic gasFiring; // Burner fires on gas
  logic [TIME_W-1:0] evacTime; // Evacuation time, ms
  logic [TIME_W-1:0] atmTime; // Atmospheric hold time, ms
  logic [TIME_W-1:0] fillTime; // Filling time, ms
  logic [TIME_W-1:0] gaspTime; // Gas pressure hold time, ms
  logic [IRQ_W-1:0] irqStatus; // Sticky event bits
  logic [IRQ_W-1:0] irqMask; // Interrupt enables
  logic [15:0] errCode; // Last error code
  logic forceTest; // Next startup must test
  logic started; // First cycle after reset done

  // Sequencer state
  gvp_state_t state;
  gvp_state_t next_state;
  logic [PRE_W-1:0] preCnt; // Cycles within one ms
  logic [TIME_W-1:0] stepMs; // Elapsed ms in this step
  logic [7:0] prevPhase; // Phase one cycle ago

  // Bus capture
  logic [7:0] awAddrQ; // Held write address
  logic [31:0] wDataQ; // Held write data
  logic [3:0] wStrbQ; // Held write strobes

  // Write decode
  logic doWrite; // Address and data both held
  logic [31:0] oldWord; // Current word at write address
  logic [31:0] newWord; // Word after byte merge
  logic wrMapped; // Write hits a register
  logic wrCtrl;
  logic wrCmd;
  logic wrEvac;
  logic wrAtm;
  logic wrFill;
  logic wrGasp;
  logic wrIrq;
  logic wrMask;
  logic manualReset; // Unlock and adopt mode

  // Read decode
  logic rdTake; // Read address taken
  logic [31:0] rdWord; // Word at read address
  logic rdMapped; // Read hits a register
  logic [31:0] statusWord; // Status register view

  // Sequencer decode
  logic pressurePresent; // Test space above switch point
  logic msTick; // One ms elapsed
  logic [TIME_W-1:0] stepLimit; // Time for current step
  logic stepDone; // Current step time over
  logic running; // In one of the four steps
  logic startupHit; // Entered startup proving phase
  logic reqHit; // A test request arrived
  logic runTest; // Request leads to a full test
  logic abortCond; // Supervised inputs opened, gas firing off or manual reset
  logic supplyLost; // Minimum gas missing
  logic leakBurner;
  logic leakGas;
  logic invalidSig;
  logic prevented; // Request refused for missing gas
  logic skipPass; // Request passes without test
  logic fullPass; // Gas hold finished clean
  logic aborted; // Running test abandoned
  logic [IRQ_W-1:0] irqSet; // Events of this cycle
  logic [IRQ_W-1:0] irqClr; // Software clears
  logic [IRQ_W-1:0] next_irqStatus;

  // Address helpers
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == REG_CTRL) || (a == REG_CMD) || (a == REG_EVAC) || (a == REG_ATM) ||
               (a == REG_FILL) || (a == REG_GASP) || (a == REG_STATUS) ||
               (a == REG_IRQ) || (a == REG_MASK);
  endfunction

  // Read view of a register
  function automatic logic [31:0] regWord(input logic [7:0] a, input logic [31:0] st);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      REG_CTRL: begin
        w[CTRL_MODE_LSB +: 2] = pendingMode;
        w[CTRL_GAS_BIT] = gasFiring;
      end
      REG_EVAC: w[TIME_W-1:0] = evacTime;
      REG_ATM: w[TIME_W-1:0] = atmTime;
      REG_FILL: w[TIME_W-1:0] = fillTime;
      REG_GASP: w[TIME_W-1:0] = gaspTime;
      REG_STATUS: w = st;
      REG_IRQ: w[IRQ_W-1:0] = irqStatus;
      REG_MASK: w[IRQ_W-1:0] = irqMask;
      default: w = 32'h0000_0000;
    endcase
    regWord = w;
  endfunction

  // Status word
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[STAT_STATE_LSB +: 3] = state;
    statusWord[STAT_MODE_LSB +: 2] = activeMode;
    statusWord[STAT_LOCK_BIT] = lockout;
    statusWord[STAT_FORCE_BIT] = forceTest;
    statusWord[STAT_PASS_BIT] = testPassed;
    statusWord[STAT_ERR_LSB +: 16] = errCode;
  end

  // Write path decode
  assign doWrite = !awready && !wready && !bvalid;
  always_comb oldWord = regWord(awAddrQ, statusWord); // Re-evaluates on any register change
  assign newWord = mergeWord(oldWord, wDataQ, wStrbQ);
  assign wrMapped = isMapped(awAddrQ);
  assign wrCtrl = doWrite && (awAddrQ == REG_CTRL);
  assign wrCmd = doWrite && (awAddrQ == REG_CMD);
  assign wrEvac = doWrite && (awAddrQ == REG_EVAC);
  assign wrAtm = doWrite && (awAddrQ == REG_ATM);
  assign wrFill = doWrite && (awAddrQ == REG_FILL);
  assign wrGasp = doWrite && (awAddrQ == REG_GASP);
  assign wrIrq = doWrite && (awAddrQ == REG_IRQ);
  assign wrMask = doWrite && (awAddrQ == REG_MASK);
  assign manualReset = wrCmd && wDataQ[CMD_MRST_BIT] && wStrbQ[0];
  assign irqClr = wrIrq ? (wDataQ[IRQ_W-1:0] & {IRQ_W{wStrbQ[0]}}) : '0; // Event bits in byte 0

  // Read path decode
  assign rdTake = arvalid && arready;
  always_comb rdWord = regWord(araddr, statusWord); // Re-evaluates on any register change
  assign rdMapped = isMapped(araddr);

  // Write address and data capture, either order
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awAddrQ <= 8'h00;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        awAddrQ <= awaddr;
      end else if (doWrite) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end else if (doWrite) begin
        wready <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read channel, one word per address
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (rdTake) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rdWord;
      rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Configuration registers; mode waits for manual reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pendingMode <= MODE_OFF;
      activeMode <= MODE_OFF;
      gasFiring <= 1'b0;
      evacTime <= STEP_TIME_RST;
      atmTime <= STEP_TIME_RST;
      fillTime <= STEP_TIME_RST;
      gaspTime <= STEP_TIME_RST;
      irqMask <= '0;
    end else begin
      if (wrCtrl) begin
        pendingMode <= gvp_mode_t'(newWord[CTRL_MODE_LSB +: 2]);
        gasFiring <= newWord[CTRL_GAS_BIT];
      end
      if (manualReset) begin
        activeMode <= pendingMode;
      end
      if (wrEvac) evacTime <= newWord[TIME_W-1:0];
      if (wrAtm) atmTime <= newWord[TIME_W-1:0];
      if (wrFill) fillTime <= newWord[TIME_W-1:0];
      if (wrGasp) gaspTime <= newWord[TIME_W-1:0];
      if (wrMask) irqMask <= newWord[IRQ_W-1:0];
    end
  end

  // Sequencer decode
  assign pressurePresent = !pins.provingClosed;
  assign msTick = (preCnt == PRE_W'(CYC_PER_STEP_MS - 1));
  assign stepLimit = (state == ST_EVAC) ? evacTime :
                     (state == ST_ATM) ? atmTime :
                     (state == ST_FILL) ? fillTime : gaspTime;
  assign stepDone = (stepMs >= stepLimit);
  assign running = (state == ST_EVAC) || (state == ST_ATM) || (state == ST_FILL) ||
                   (state == ST_GASP);
  assign startupHit = (seqPhase == PHASE_PROVING) && (prevPhase != PHASE_PROVING);
  assign reqHit = (state == ST_IDLE) && !lockout && started && (startupHit || shutdownReq);
  assign supplyLost = !pins.gasStartClosed;
  // Only on gas with the test enabled; forced test also on startup
  assign runTest = gasFiring && (activeMode != MODE_OFF) &&
                   ((startupHit && (activeMode[0] || forceTest)) ||
                    (shutdownReq && activeMode[1]));
  assign prevented = reqHit && runTest && supplyLost;
  assign skipPass = reqHit && !runTest;
  assign abortCond = !pins.safetyClosed || supplyLost || !gasFiring || manualReset;
  assign aborted = running && abortCond;
  assign leakBurner = (state == ST_ATM) && !abortCond && pressurePresent;
  assign invalidSig = (state == ST_FILL) && !abortCond && stepDone && !pressurePresent;
  assign leakGas = (state == ST_GASP) && !abortCond && !pressurePresent;
  assign fullPass = (state == ST_GASP) && !abortCond && !leakGas && stepDone;

  // Next state: steps strictly in order
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (lockout) next_state = ST_LOCK;
        else if (reqHit && runTest && !supplyLost && pins.safetyClosed) next_state = ST_EVAC;
      end
      ST_EVAC: begin
        if (abortCond) next_state = ST_IDLE;
        else if (stepDone) next_state = ST_ATM;
      end
      ST_ATM: begin
        if (abortCond) next_state = ST_IDLE;
        else if (leakBurner) next_state = ST_LOCK;
        else if (stepDone) next_state = ST_FILL;
      end
      ST_FILL: begin
        if (abortCond) next_state = ST_IDLE;
        else if (invalidSig) next_state = ST_LOCK;
        else if (stepDone) next_state = ST_GASP;
      end
      ST_GASP: begin
        if (abortCond) next_state = ST_IDLE;
        else if (leakGas) next_state = ST_LOCK;
        else if (stepDone) next_state = ST_IDLE;
      end
      ST_LOCK: begin
        if (manualReset) next_state = ST_IDLE;
      end
      default: next_state = ST_LOCK;
    endcase
  end

  // State and step timer, restarted on every step change
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      preCnt <= '0;
      stepMs <= '0;
      prevPhase <= 8'h00;
    end else begin
      state <= next_state;
      prevPhase <= seqPhase;
      if (next_state != state) begin
        preCnt <= '0;
        stepMs <= '0;
      end else if (msTick) begin
        preCnt <= '0;
        stepMs <= stepDone ? stepMs : stepMs + 1'b1;
      end else begin
        preCnt <= preCnt + 1'b1;
      end
    end
  end

  // Lockout, error code and forced-test memory
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      started <= 1'b0;
      lockout <= 1'b0;
      errCode <= ERR_NONE;
      forceTest <= 1'b1;
      testPassed <= 1'b0;
    end else begin
      started <= 1'b1;
      if (!started) lockout <= nvLockoutIn;
      else if (leakBurner || leakGas || invalidSig) lockout <= 1'b1;
      else if (manualReset) lockout <= 1'b0;
      if (leakGas) errCode <= ERR_LEAK_GAS;
      else if (leakBurner) errCode <= ERR_LEAK_BURNER;
      else if (invalidSig) errCode <= ERR_INVALID;
      else if (prevented || (aborted && supplyLost)) errCode <= ERR_SUPPLY;
      else if (manualReset) errCode <= ERR_NONE;
      if (manualReset || aborted || prevented) forceTest <= 1'b1;
      else if (fullPass && startupHit == 1'b0) forceTest <= 1'b0;
      if (fullPass || skipPass) testPassed <= 1'b1;
      else if (reqHit || aborted || lockout) testPassed <= 1'b0;
    end
  end

  // Sticky events, set wins over a clear
  assign irqSet[IRQ_DONE] = fullPass;
  assign irqSet[IRQ_LEAKG] = leakGas;
  assign irqSet[IRQ_LEAKB] = leakBurner;
  assign irqSet[IRQ_INVAL] = invalidSig;
  assign irqSet[IRQ_SUPPLY] = prevented || (aborted && supplyLost);
  assign irqSet[IRQ_ABORT] = aborted;
  assign next_irqStatus = (irqStatus & ~irqClr) | irqSet;

  // Interrupt status and output
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqStatus <= '0;
      irq <= 1'b0;
    end else begin
      irqStatus <= next_irqStatus;
      irq <= |(next_irqStatus & irqMask);
    end
  end

  // Valve and block outputs, only the tested valve opens
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      burnerValve <= 1'b0;
      mainsValve <= 1'b0;
      ignitionBlock <= 1'b0;
      testBusy <= 1'b0;
    end else begin
      burnerValve <= (next_state == ST_EVAC);
      mainsValve <= (next_state == ST_FILL);
      ignitionBlock <= (next_state != ST_IDLE) || (!started && nvLockoutIn);
      testBusy <= (next_state == ST_EVAC) || (next_state == ST_ATM) ||
                  (next_state == ST_FILL) || (next_state == ST_GASP);
    end
  end

endmodule

// ===== gvp_sequencer_props.sv
// Concurrent checks on the sequencer outputs
`timescale 1ns/1ps
module gvp_sequencer_props
  import gvp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wvalid,
  input wire gvp_pins_t pinsIn,
  input wire logic burnerValve,
  input wire logic mainsValve,
  input wire logic ignitionBlock,
  input wire logic testBusy,
  input wire logic testPassed,
  input wire logic lockout
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_valves_exclusive: assert property (!(burnerValve && mainsValve))
    else $error("both valves open");
  a_idle_valves_shut: assert property (!testBusy |-> !burnerValve && !mainsValve)
    else $error("valve open outside test");
  a_test_starts_evac: assert property ($rose(testBusy) |-> burnerValve && !mainsValve)
    else $error("test did not start with evacuation");
  a_atm_hold_closed: assert property ($fell(burnerValve) && testBusy |-> !mainsValve [*2])
    else $error("mains opened right after evacuation");
  a_busy_blocks_ign: assert property (testBusy |-> ignitionBlock)
    else $error("ignition free during test");
  a_lock_blocks_all: assert property (lockout |-> ignitionBlock && !testBusy)
    else $error("lockout not blocking");
  a_lock_persists: assert property (lockout && !wvalid && !$past(wvalid) |=> lockout)
    else $error("lockout dropped without write");
  a_pass_clean: assert property (testPassed |-> !testBusy && !lockout)
    else $error("pass flagged while busy or locked");
  a_safety_abort: assert property (!pinsIn.safetyClosed [*8] |-> !burnerValve && !mainsValve)
    else $error("valves open with safety loop open");

  c_pass: cover property ($fell(testBusy) && testPassed);
  c_lock: cover property ($rose(lockout));
  c_fill: cover property ($rose(mainsValve));
endmodule

bind gvp_sequencer gvp_sequencer_props u_props (.clk(clk), .nrst(nrst), .wvalid(wvalid),
  .pinsIn(pinsIn), .burnerValve(burnerValve), .mainsValve(mainsValve),
  .ignitionBlock(ignitionBlock), .testBusy(testBusy), .testPassed(testPassed),
  .lockout(lockout));

// ===== gvp_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module gvp_sync
  import gvp_pkg::*;
#(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1; // First stage, read only by s2
  logic [WIDTH-1:0] s2; // Second stage
  logic [WIDTH-1:0] s3; // Third stage
  logic [WIDTH-1:0] agree; // Bits where stage two and three match

  assign agree = ~(s2 ^ s3);

  // Shift chain and filtered output
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= (s2 & agree) | (dout & ~agree);
    end
  end

endmodule

// ===== gvp_valve_model.sv
// Far-side model: two gas valves and the proving pressure switch
`timescale 1ns/1ps
module gvp_valve_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic burnerValve,
  input wire logic mainsValve,
  input wire logic [1:0] leakMode,
  output logic provingClosed
);
  // Test space pressure, 1 = above switch point
  logic press;
  // Vent, fill or leak the space between the valves
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      press <= 1'b0;
    end else if (burnerValve) begin
      press <= 1'b0;
    end else if (mainsValve) begin
      press <= (leakMode != 2'h3);
    end else if (leakMode == 2'h1) begin
      press <= 1'b1;
    end else if (leakMode == 2'h2) begin
      press <= 1'b0;
    end
  end
  // Contact opens while pressure is present
  assign provingClosed = !press;
endmodule

// ===== test_gas_valve_proving_sequencer.sv
// Self-checking bench for the gas valve proving sequencer
`timescale 1ns/1ps
module test_gas_valve_proving_sequencer
  import gvp_pkg::*;
;
  // One table row: setup and expected outcome
  typedef struct packed {
    logic [1:0] mode;
    logic gas;
    logic [1:0] leak;
    logic [15:0] err;
    logic lock;
    logic pass;
  } gvp_row_t;
  logic clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, shutdownReq, nvLockoutIn, burnerValve, mainsValve, ignitionBlock;
  logic testBusy, testPassed, lockout, irq, provingClosed, safetyClosed, gasStartClosed;
  logic [7:0] awaddr, araddr, seqPhase;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs, leakMode;
  gvp_pins_t pinsIn;
  int errTotal, cmpCount;
  gvp_row_t rows[7];

  // 20 MHz clock
  always #25 clk = ~clk;
  assign pinsIn = {provingClosed, safetyClosed, gasStartClosed};

  gvp_sequencer #(.CYC_PER_STEP_MS(4)) uut (.clk(clk), .nrst(nrst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pinsIn(pinsIn), .seqPhase(seqPhase), .shutdownReq(shutdownReq),
    .nvLockoutIn(nvLockoutIn), .burnerValve(burnerValve), .mainsValve(mainsValve),
    .ignitionBlock(ignitionBlock), .testBusy(testBusy), .testPassed(testPassed),
    .lockout(lockout), .irq(irq));
  gvp_valve_model far (.clk(clk), .nrst(nrst), .burnerValve(burnerValve),
    .mainsValve(mainsValve), .leakMode(leakMode), .provingClosed(provingClosed));

  // Compare one value
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmpCount++;
    if (g !== e) begin
      errTotal++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // AXI4-Lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && ++n < 50);
    if (n >= 50) errTotal++;
    r = bresp;
    bready <= 1'b0;
  endtask
  // AXI4-Lite read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && ++n < 50);
    if (n >= 50) errTotal++;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Enter startup phase 30
  task automatic req();
    @(posedge clk);
    seqPhase <= PHASE_PROVING;
    repeat (3) @(posedge clk);
    seqPhase <= 8'h00;
  endtask
  // Wait for pass or lockout, bounded
  task automatic wt();
    int n;
    n = 0;
    do @(posedge clk); while (!(testPassed || lockout) && ++n < 400);
    if (n >= 400) errTotal++;
    #1;
  endtask
  // Let outputs settle
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Verdict and end of run
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (30000) @(posedge clk);
    errTotal++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    clk = 0; nrst = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hf; seqPhase = 0; shutdownReq = 0;
    nvLockoutIn = 0; leakMode = 0; safetyClosed = 1; gasStartClosed = 1;
    errTotal = 0; cmpCount = 0;
    rows = '{'{MODE_STARTUP, 1, 0, ERR_NONE, 0, 1}, '{MODE_STARTUP, 1, 1, ERR_LEAK_BURNER, 1, 0},
      '{MODE_STARTUP, 1, 2, ERR_LEAK_GAS, 1, 0}, '{MODE_SHUTDOWN, 1, 3, ERR_INVALID, 1, 0},
      '{MODE_OFF, 1, 1, ERR_NONE, 0, 1}, '{MODE_BOTH, 0, 1, ERR_NONE, 0, 1},
      '{MODE_BOTH, 1, 0, ERR_NONE, 0, 1}};
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++) wr(REG_EVAC + 8'(4 * i), 32'h2, rs);
    wr(REG_MASK, 32'h3f, rs);
    foreach (rows[i]) begin
      wr(REG_CTRL, {29'h0, rows[i].gas, rows[i].mode}, rs);
      wr(REG_CMD, 32'h1, rs);
      leakMode <= rows[i].leak;
      req();
      wt();
      chk(lockout, rows[i].lock);
      chk(testPassed, rows[i].pass);
      rd(REG_STATUS, v, rs);
      chk(v[31:16], rows[i].err);
      $display("row %0d done", i);
    end
    // Interrupt raised, masked, cleared
    #1;
    chk(irq, 1'b1);
    wr(REG_MASK, 32'h0, rs);
    settle();
    chk(irq, 1'b0);
    wr(REG_MASK, 32'h3f, rs);
    wr(REG_IRQ, 32'h3f, rs);
    settle();
    chk(irq, 1'b0);
    // New mode waits for manual reset
    wr(REG_CTRL, 32'h4, rs);
    rd(REG_STATUS, v, rs);
    chk(v[4:3], 2'h3);
    leakMode <= 2'h1;
    @(posedge clk) shutdownReq <= 1'b1;
    @(posedge clk) shutdownReq <= 1'b0;
    wt();
    chk(lockout, 1'b1);
    wr(REG_CMD, 32'h1, rs);
    rd(REG_STATUS, v, rs);
    chk(v[6:3], 4'h8);
    $display("mode test done");
    // Safety loop opens mid-test
    wr(REG_CTRL, 32'h7, rs);
    wr(REG_CMD, 32'h1, rs);
    leakMode <= 2'h0;
    wr(REG_IRQ, 32'h3f, rs);
    @(posedge clk) seqPhase <= PHASE_PROVING;
    repeat (3) @(posedge clk);
    #1;
    chk({burnerValve, mainsValve}, 2'h2);
    repeat (9) @(posedge clk);
    safetyClosed <= 1'b0;
    seqPhase <= 8'h00;
    settle();
    repeat (10) @(posedge clk);
    chk(testBusy, 1'b0);
    chk(irq, 1'b1);
    rd(REG_IRQ, v, rs);
    chk(v[IRQ_ABORT], 1'b1);
    safetyClosed <= 1'b1;
    rd(REG_STATUS, v, rs);
    chk(v[STAT_FORCE_BIT], 1'b1);
    $display("abort test done");
    // Missing minimum gas pressure
    gasStartClosed <= 1'b0;
    repeat (8) @(posedge clk);
    req();
    repeat (20) @(posedge clk);
    rd(REG_STATUS, v, rs);
    chk(v[31:16], ERR_SUPPLY);
    gasStartClosed <= 1'b1;
    // Unmapped address
    wr(8'h40, 32'h1, rs);
    chk(rs, RESP_SLVERR);
    rd(8'h40, v, rs);
    chk(rs, RESP_SLVERR);
    chk(v, 32'h0);
    $display("supply and bus test done");
    // Reset restores stored lockout and defaults
    nvLockoutIn <= 1'b1;
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    settle();
    chk(lockout, 1'b1);
    chk(ignitionBlock, 1'b1);
    rd(REG_EVAC, v, rs);
    chk(v, {16'h0, STEP_TIME_RST});
    $display("reset test done");
    report_and_stop();
  end
endmodule
